/* File: verilog/aoc_pkg.sv */
// Constants, types and register map of the analog output code handler
package aoc_pkg;

   // Register byte offsets on the Avalon-MM slave
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_SUBST  = 4'h4;
   localparam logic [3:0] ADDR_DATA   = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'hc;

   // Control register fields
   localparam int CTRL_RANGE_LSB = 0;
   localparam int CTRL_KEEP_BIT  = 2;
   localparam int CTRL_BUILT_BIT = 3;
   localparam logic [1:0] RSEL_VOLT = 2'h0;
   localparam logic [1:0] RSEL_CUR0 = 2'h1;
   localparam logic [1:0] RSEL_CUR4 = 2'h2;

   // Reset values
   localparam logic [3:0]  CTRL_RESET  = 4'h0;
   localparam logic [15:0] SUBST_RESET = 16'h0000;
   localparam logic [15:0] DATA_RESET  = 16'h0000;

   // Data word thresholds
   localparam logic signed [15:0] WORD_OVF_MIN   = 16'sh7f00;
   localparam logic signed [15:0] WORD_UNF_MAX   = 16'sh80ff;
   localparam logic signed [15:0] WORD_RATED_MAX = 16'sh6c00;
   localparam logic signed [15:0] WORD_RATED_MIN = 16'sh9400;
   localparam logic signed [15:0] WORD_CUR4_ZERO = 16'she500;
   localparam logic signed [15:0] WORD_ZERO      = 16'sh0000;

   // Status register bit positions
   localparam int ST_OVF_BIT   = 0;
   localparam int ST_UNF_BIT   = 1;
   localparam int ST_OVSH_BIT  = 2;
   localparam int ST_UNSH_BIT  = 3;
   localparam int ST_SHORT_BIT = 4;
   localparam int ST_WIRE_BIT  = 5;
   localparam int ST_RUN_BIT   = 6;
   localparam int ST_CODE_LSB  = 16;

   // Number of pin inputs that pass the synchroniser
   localparam int SYNC_W = 3;

   typedef enum logic [2:0]
   {
      RNG_VOLT = 3'b001,
      RNG_CUR0 = 3'b010,
      RNG_CUR4 = 3'b100
   } aoc_range_t;

   typedef enum logic [1:0]
   {
      ST_RUN  = 2'b01,
      ST_STOP = 2'b10
   } aoc_state_t;

   typedef struct packed
   {
      logic overflow;
      logic underflow;
      logic overshoot;
      logic undershoot;
      logic negative;
      logic below_cur4;
   } aoc_class_t;

endpackage

/* File: verilog/aoc_classify.sv */
// Band classification of a signed output data word
module aoc_classify
   import aoc_pkg::*;
(
   // Word in
   input  wire logic signed [15:0] word,
   // Bands out
   output aoc_class_t              cls
);

   wire over_w  = word >= WORD_OVF_MIN;
   wire under_w = word <= WORD_UNF_MAX;

   assign cls.overflow   = over_w;
   assign cls.underflow  = under_w;
   assign cls.overshoot  = (word > WORD_RATED_MAX) && !over_w;
   assign cls.undershoot = (word < WORD_RATED_MIN) && !under_w;
   assign cls.negative   = word < WORD_ZERO;
   assign cls.below_cur4 = word < WORD_CUR4_ZERO;

endmodule

/* File: verilog/aoc_channel.sv */
// Analog output channel code handler with Avalon-MM register slave
//
// Behaviour
// RULE_01 - Channel range is one of: plus/minus 10 V, 0-20 mA, 4-20 mA.
// RULE_02 - Voltage range: words -27648..27648 are the rated span, passed to converter.
// RULE_03 - Current ranges: words 0..27648 are the rated span, 27648 is full current.
// RULE_04 - Words >= 32512 or <= -32513 drive the substitute value instead.
// RULE_05 - In STOP the output holds last value or takes substitute; substitute resets to 0.
// RULE_06 - 4-20 mA: words down to -6912 convert; lower words clamp to zero current.
// RULE_07 - Short-to-ground diagnostic only in voltage range.
// RULE_08 - Wire-break diagnostic only in current ranges.
// RULE_09 - Built-in 0-20 mA output: negative words produce zero output.
// RULE_10 - Overshoot/undershoot convert linearly; overflow/underflow raise a diagnostic.
module aoc_channel
   import aoc_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // Avalon-MM slave
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // Controller state and field sense pins
   input  wire logic        cpu_run,
   input  wire logic        short_gnd_in,
   input  wire logic        wire_break_in,
   // Converter code and diagnostics
   output logic      [15:0] dac_code,
   output logic             diag_overflow,
   output logic             diag_underflow,
   output logic             diag_short,
   output logic             diag_wire_break
);

   // Byte-lane merge for the 16-bit registers
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   logic [3:0]        ctrl;
   logic [15:0]       subst;
   logic [15:0]       data;
   aoc_state_t        state;
   logic [SYNC_W-1:0] sync1;
   logic [SYNC_W-1:0] sync2;
   logic              overshoot_q;
   logic              undershoot_q;
   aoc_class_t        cls;

   // Pin synchronisers
   wire [SYNC_W-1:0] pins_in = {wire_break_in, short_gnd_in, cpu_run};
   genvar g;
   generate
      for (g = 0; g < SYNC_W; g++)
      begin : g_sync
         always_ff @(posedge clock or posedge rst)
         begin
            if (rst)
            begin
               sync1[g] <= 1'b0;
               sync2[g] <= 1'b0;
            end
            else
            begin
               sync1[g] <= pins_in[g];
               sync2[g] <= sync1[g];
            end
         end
      end
   endgenerate
   wire run_s   = sync2[0];
   wire short_s = sync2[1];
   wire wire_s  = sync2[2];

   // Bus decode: request taken on the cycle waitrequest is low
   wire        req       = read | write;
   wire        do_write  = write & ~waitrequest;
   wire        sel_ctrl  = address == ADDR_CTRL;
   wire        sel_subst = address == ADDR_SUBST;
   wire        sel_data  = address == ADDR_DATA;
   wire        sel_stat  = address == ADDR_STATUS;
   wire        next_wait = ~(req & waitrequest);

   // Effective range; built-in output is a fixed 0-20 mA channel
   wire        builtin  = ctrl[CTRL_BUILT_BIT];
   wire        keep     = ctrl[CTRL_KEEP_BIT];
   wire [1:0]  rsel     = ctrl[CTRL_RANGE_LSB +: 2];
   aoc_range_t rng;
   assign rng = builtin ? RNG_CUR0 :                      // RULE_09
                (rsel == RSEL_CUR0) ? RNG_CUR0 :          // RULE_01
                (rsel == RSEL_CUR4) ? RNG_CUR4 : RNG_VOLT;

   aoc_classify u_classify
   (
      .word (data),
      .cls  (cls)
   );

   // Converted code while running
   logic [15:0] run_code;
   wire  out_of_band = cls.overflow | cls.underflow;                          // RULE_04
   wire  cur0_zero   = (rng == RNG_CUR0) & cls.negative;                      // RULE_03 RULE_09
   wire  cur4_clamp  = (rng == RNG_CUR4) & cls.below_cur4;                    // RULE_06
   assign run_code = out_of_band ? subst :                                    // RULE_04
                     cur0_zero   ? WORD_ZERO :
                     cur4_clamp  ? WORD_CUR4_ZERO :                           // RULE_06
                     data;                                                    // RULE_02 RULE_10

   // STOP output: hold the last code or drive the substitute
   wire [15:0] next_dac   = (state == ST_RUN) ? run_code : (keep ? dac_code : subst);   // RULE_05
   aoc_state_t next_state;
   assign next_state = run_s ? ST_RUN : ST_STOP;

   // Status: diagnostics in the low bits, live code in the upper half
   wire [31:0] status_word = {dac_code, 9'h000, state == ST_RUN, diag_wire_break, diag_short,
                              undershoot_q, overshoot_q, diag_underflow, diag_overflow};
   wire [31:0] next_rdata  = sel_ctrl  ? {28'h0000000, ctrl} :
                             sel_subst ? {16'h0000, subst} :
                             sel_data  ? {16'h0000, data} :
                             sel_stat  ? status_word : 32'h00000000;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         waitrequest <= 1'b1;
         readdata    <= 32'h00000000;
         ctrl        <= CTRL_RESET;
         subst       <= SUBST_RESET;                                          // RULE_05
         data        <= DATA_RESET;
      end
      else
      begin
         waitrequest <= next_wait;
         if (read & waitrequest)
            readdata <= next_rdata;
         if (do_write & sel_ctrl & byteenable[0])
            ctrl <= writedata[3:0];
         if (do_write & sel_subst)
            subst <= merge16(subst, writedata, byteenable);
         if (do_write & sel_data)
            data <= merge16(data, writedata, byteenable);
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state           <= ST_STOP;
         dac_code        <= SUBST_RESET;
         diag_overflow   <= 1'b0;
         diag_underflow  <= 1'b0;
         overshoot_q     <= 1'b0;
         undershoot_q    <= 1'b0;
         diag_short      <= 1'b0;
         diag_wire_break <= 1'b0;
      end
      else
      begin
         state           <= next_state;
         dac_code        <= next_dac;                                         // RULE_05
         diag_overflow   <= cls.overflow;                                     // RULE_10
         diag_underflow  <= cls.underflow;                                    // RULE_10
         overshoot_q     <= cls.overshoot;
         undershoot_q    <= cls.undershoot & (rng == RNG_VOLT);
         diag_short      <= short_s & (rng == RNG_VOLT);                      // RULE_07
         diag_wire_break <= wire_s & (rng != RNG_VOLT);                       // RULE_08
      end
   end

   // Checks
   a_ovf_subst: assert property (@(posedge clock) disable iff (rst) // RULE_04
      (state == ST_RUN && cls.overflow) |=> dac_code == $past(subst))
      else $error("overflow did not drive substitute");
   a_unf_subst: assert property (@(posedge clock) disable iff (rst) // RULE_04
      (state == ST_RUN && cls.underflow) |=> dac_code == $past(subst))
      else $error("underflow did not drive substitute");
   a_volt_pass: assert property (@(posedge clock) disable iff (rst) // RULE_02
      (state == ST_RUN && rng == RNG_VOLT && !out_of_band) |=> dac_code == $past(data))
      else $error("voltage word not passed");
   a_cur0_pass: assert property (@(posedge clock) disable iff (rst) // RULE_03
      (state == ST_RUN && rng == RNG_CUR0 && !out_of_band && !cls.negative) |=> dac_code == $past(data))
      else $error("0-20 mA word not passed");
   a_cur4_pass: assert property (@(posedge clock) disable iff (rst) // RULE_06
      (state == ST_RUN && rng == RNG_CUR4 && !out_of_band && !cls.below_cur4) |=> dac_code == $past(data))
      else $error("4-20 mA word not passed");
   a_cur4_clamp: assert property (@(posedge clock) disable iff (rst) // RULE_06
      (state == ST_RUN && rng == RNG_CUR4 && $signed(data) < $signed(WORD_CUR4_ZERO) && !cls.underflow)
      |=> dac_code == WORD_CUR4_ZERO) else $error("4-20 mA clamp missing");
   a_cur0_neg: assert property (@(posedge clock) disable iff (rst) // RULE_09
      (state == ST_RUN && rng == RNG_CUR0 && data[15] && !cls.underflow) |=> dac_code == WORD_ZERO)
      else $error("negative current word not zeroed");
   a_stop_keep: assert property (@(posedge clock) disable iff (rst) // RULE_05
      (state == ST_STOP && keep) |=> $stable(dac_code))
      else $error("stop hold changed output");
   a_stop_subst: assert property (@(posedge clock) disable iff (rst) // RULE_05
      (state == ST_STOP && !keep) |=> dac_code == $past(subst))
      else $error("stop substitute missing");
   a_short_volt: assert property (@(posedge clock) disable iff (rst) // RULE_07
      (rng != RNG_VOLT) |=> !diag_short)
      else $error("short diagnostic in current range");
   a_short_pass: assert property (@(posedge clock) disable iff (rst) // RULE_07
      (rng == RNG_VOLT && short_s) |=> diag_short)
      else $error("short diagnostic missing in voltage range");
   a_wire_cur: assert property (@(posedge clock) disable iff (rst) // RULE_08
      (rng == RNG_VOLT) |=> !diag_wire_break)
      else $error("wire break in voltage range");
   a_wire_pass: assert property (@(posedge clock) disable iff (rst) // RULE_08
      (rng != RNG_VOLT && wire_s) |=> diag_wire_break)
      else $error("wire break missing in current range");
   a_ovf_diag: assert property (@(posedge clock) disable iff (rst) // RULE_10
      cls.overflow |=> diag_overflow)
      else $error("overflow diagnostic missing");
   a_unf_diag: assert property (@(posedge clock) disable iff (rst) // RULE_10
      cls.underflow |=> diag_underflow)
      else $error("underflow diagnostic missing");
   a_bus_wait: assert property (@(posedge clock) disable iff (rst)
      (req && waitrequest) |=> !waitrequest ##1 waitrequest)
      else $error("bus answer not one cycle");

   // Main scenarios
   c_ovf_run:   cover property (@(posedge clock) disable iff (rst) state == ST_RUN && cls.overflow);
   c_run_stop:  cover property (@(posedge clock) disable iff (rst) state == ST_RUN ##1 state == ST_STOP);
   c_cur4:      cover property (@(posedge clock) disable iff (rst) state == ST_RUN && cur4_clamp);
   c_stop_keep: cover property (@(posedge clock) disable iff (rst) state == ST_STOP && keep);
   c_builtin:   cover property (@(posedge clock) disable iff (rst) state == ST_RUN && builtin);

endmodule

/* File: tb/aoc_ctl_model.sv */
// Controller model: Avalon-MM master that writes configuration and data words
module aoc_ctl_model
   import aoc_pkg::*;
(
   // Clock
   input  wire logic        clock,
   // Avalon-MM master side
   output logic      [3:0]  address,
   output logic             read,
   output logic             write,
   output logic      [31:0] writedata,
   output logic      [3:0]  byteenable,
   input  wire logic        waitrequest
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      address    = 4'h0;
      read       = 1'b0;
      write      = 1'b0;
      writedata  = 32'h0000_0000;
      byteenable = 4'hf;
   end

   // Request stays put until waitrequest is sampled low at a rising edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      address   <= a;
      writedata <= d;
      write     <= wr;
      read      <= ~wr;
      @(posedge clock);
      while (waitrequest !== 1'b0)
         @(posedge clock);
      write <= 1'b0;
      read  <= 1'b0;
   endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the analog output code handler
module testbench
   import aoc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        cpu_run = 1'b0;
   logic        short_gnd_in = 1'b0;
   logic        wire_break_in = 1'b0;
   logic [3:0]  address;
   logic [3:0]  byteenable;
   logic        read;
   logic        write;
   logic        waitrequest;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic [15:0] dac_code;
   logic        diag_overflow;
   logic        diag_underflow;
   logic        diag_short;
   logic        diag_wire_break;
   logic [15:0] subst;
   logic [32:0] exp_q[$];
   logic [15:0] words[12] = '{16'h6c00, 16'h9400, 16'h7eff, 16'h7f00, 16'h7fff, 16'h8100,
                              16'h80ff, 16'h8000, 16'hffff, 16'he500, 16'he4ff, 16'h0000};
   int          miscompares = 0;
   int          total_checks = 0;
   event        chk_ev;

   always #5 clock = ~clock;

   aoc_channel u_aoc_channel (.clock, .rst, .address, .read, .write, .writedata, .byteenable, .readdata,
      .waitrequest, .cpu_run, .short_gnd_in, .wire_break_in, .dac_code, .diag_overflow, .diag_underflow,
      .diag_short, .diag_wire_break);
   aoc_ctl_model u_aoc_ctl_model (.clock, .address, .read, .write, .writedata, .byteenable, .waitrequest);

   // Expected code and diagnostics: {code, overflow, underflow, short, wire break}
   function automatic logic [19:0] model(logic [1:0] rs, logic signed [15:0] w, logic sg, logic wb);
      logic [15:0] c;
      logic        ov;
      logic        un;
      ov = w >= 16'sh7f00;
      un = w <= 16'sh80ff;
      c = w;
      if (rs == RSEL_CUR0 && w[15])
         c = 16'h0000;
      if (rs == RSEL_CUR4 && w < 16'she500)
         c = 16'he500;
      if (ov || un)
         c = subst;
      return {c, ov, un, sg & (rs == RSEL_VOLT), wb & (rs != RSEL_VOLT)};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Queue an expectation; kind 1 is read data, kind 0 the converter outputs
   task automatic note(input logic k, input logic [31:0] v);
      exp_q.push_back({k, v});
      @(posedge clock);
      @(negedge clock);
      -> chk_ev;
   endtask

   always @(chk_ev)
   begin
      logic [32:0] e;
      e = exp_q.pop_front();
      check({12'h000, dac_code, diag_overflow, diag_underflow, diag_short, diag_wire_break}, e[31:0]);
   end

   // Read data is taken at the edge where waitrequest is sampled low
   always @(posedge clock)
   begin
      logic [32:0] e;
      if (read === 1'b1 && waitrequest === 1'b0)
      begin
         e = exp_q.pop_front();
         check(readdata, e[31:0]);
      end
   end

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      u_aoc_ctl_model.bus(1'b1, a, d);
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      exp_q.push_back({1'b1, exp});
      u_aoc_ctl_model.bus(1'b0, a, 32'h0000_0000);
   endtask

   task automatic try(input logic [1:0] rs, input logic [15:0] w);
      wr(ADDR_CTRL, {30'h0, rs});
      wr(ADDR_DATA, {16'h0000, w});
      note(1'b0, {12'h000, model(rs, w, short_gnd_in, wire_break_in)});
   endtask

   initial
   begin
      repeat (20000) @(posedge clock);
      miscompares++;
      stop_test();
   end

   initial
   begin
      void'($urandom(32'ha6d2c8dc));
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      rd_chk(ADDR_CTRL, 32'h0000_0000);
      rd_chk(ADDR_SUBST, 32'h0000_0000);
      rd_chk(4'h2, 32'h0000_0000);
      subst = 16'($urandom);
      wr(ADDR_SUBST, {16'h0000, subst});
      rd_chk(ADDR_SUBST, {16'h0000, subst});
      cpu_run       <= 1'b1;
      short_gnd_in  <= 1'b1;
      wire_break_in <= 1'b1;
      repeat (6) @(posedge clock);
      for (int r = 0; r < 3; r++)
      begin
         words[11] = 16'($urandom_range(0, 27648));
         for (int i = 0; i < 12; i++)
            try(r[1:0], words[i]);
      end
      // Voltage undershoot and overshoot seen through the status word
      wr(ADDR_CTRL, 32'h0000_0000);
      wr(ADDR_DATA, 32'h0000_8100);
      rd_chk(ADDR_STATUS, 32'h8100_0058);
      wr(ADDR_DATA, 32'h0000_7eff);
      rd_chk(ADDR_STATUS, 32'h7eff_0054);
      rd_chk(ADDR_DATA, 32'h0000_7eff);
      // Built-in channel forces the 0 to 20 mA behaviour
      wr(ADDR_CTRL, 32'h0000_0008);
      wr(ADDR_DATA, 32'h0000_ffff);
      note(1'b0, {12'h000, 16'h0000, 4'h1});
      rd_chk(ADDR_STATUS, 32'h0000_0060);
      wr(ADDR_CTRL, 32'h0000_0004);
      wr(ADDR_DATA, 32'h0000_1234);
      short_gnd_in  <= 1'b0;
      wire_break_in <= 1'b0;
      cpu_run       <= 1'b0;
      repeat (6) @(posedge clock);
      wr(ADDR_DATA, 32'h0000_0567);
      note(1'b0, {12'h000, 16'h1234, 4'h0});
      wr(ADDR_CTRL, 32'h0000_0000);
      note(1'b0, {12'h000, subst, 4'h0});
      stop_test();
   end
endmodule
